// file: pdu_cmd_port.sv
// Serial command port with keepalive pulse generation
// Contract
// (RULE1) Link runs fixed at 9600 bits per second
// (RULE2) Start, eight data bits LSB first, stop
// (RULE3) Receive and transmit run independently
// (RULE4) Execute command; answer only read commands
// (RULE5) Controller waits for response end
// (RULE6) Code 01 returns class byte
// (RULE7) Code 02 returns status byte
// (RULE8) Code 03 returns input voltage
// (RULE9) Code 04 enables keepalive pulses
// (RULE10) Code 05 disables keepalive pulses
// (RULE11) Pulses never start without enable command
// (RULE12) Pulse form follows source supported kind
// (RULE13) Long and short pulse forms offered
// (RULE14) Pulses toggle transmit pin, no frames
// (RULE15) Controller ignores transmit line while pulsing
// (RULE16) Disable restores ordinary serial operation
// (RULE17) Class byte: requested 7:4, granted 3:0
// (RULE18) Status bit 5: pulse kind, 1 short
// (RULE19) Voltage: high byte then low byte
// (RULE20) No response after enable command
// (RULE21) Unknown codes ignored, pulse state kept
`timescale 1ns/1ns
module pdu_cmd_port
  import pdu_pkg::*;
#(
  parameter int unsigned BIT_CYC = BIT_CYCLES,
  parameter int unsigned LONG_HIGH = LONG_HIGH_CYC,
  parameter int unsigned LONG_PERIOD = LONG_PERIOD_CYC,
  parameter int unsigned SHORT_HIGH = SHORT_HIGH_CYC,
  parameter int unsigned SHORT_PERIOD = SHORT_PERIOD_CYC
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic rxd,
  output logic txd,
  input wire logic [3:0] classRequested,
  input wire logic [3:0] classGranted,
  input wire logic autoclassEn,
  input wire logic [2:0] levelPulseCount,
  input wire logic sourcePulseKind,
  input wire logic [15:0] inputVoltage,
  output logic pulsesOn,
  output logic txBusy
);
  localparam int unsigned BW = $clog2(BIT_CYC + 1);
  localparam logic [BW-1:0] LAST = BW'(BIT_CYC - 1);

  logic [7:0] rxByte;
  logic rxValid;

  pdu_uart_rx #(.BIT_CYC(BIT_CYC)) u_rx (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .rxd(rxd),
    .rxByte(rxByte),
    .rxValid(rxValid)
  );

  pdu_tx_e tx_q, tx_d;
  logic [BW-1:0] bit_q, bit_d;
  logic [2:0] idx_q, idx_d;
  logic [7:0] data_q, data_d, pendByte_q, pendByte_d;
  logic pend_q, pend_d, on_q, on_d;
  logic canAnswer;
  logic [7:0] statusByte;

  // ==========================================================
  // Command decode and transmitter
  always_comb begin
    statusByte = 8'h00;
    statusByte[STATUS_KIND_BIT] = sourcePulseKind; // [RULE18]
    statusByte[STATUS_AUTO_BIT] = autoclassEn;
    statusByte[2:0] = levelPulseCount; // [RULE7]
    canAnswer = !on_q && tx_q == TX_IDLE && !pend_q; // [RULE5]
    tx_d = tx_q;
    bit_d = (tx_q == TX_IDLE || bit_q == LAST) ? '0 : bit_q + BW'(1);
    idx_d = idx_q;
    data_d = data_q;
    pend_d = pend_q;
    pendByte_d = pendByte_q;
    on_d = on_q;
    case (tx_q)
      TX_IDLE: if (pend_q) begin
        data_d = pendByte_q; // [RULE19]
        pend_d = 1'b0;
        tx_d = TX_START;
      end
      TX_START: if (bit_q == LAST) begin
        tx_d = TX_DATA;
        idx_d = '0;
      end
      TX_DATA: if (bit_q == LAST) begin
        if (idx_q == 3'h7) tx_d = TX_STOP; // [RULE2]
        else idx_d = idx_q + 3'h1;
      end
      TX_STOP: if (bit_q == LAST) tx_d = TX_IDLE;
      default: tx_d = TX_IDLE;
    endcase
    if (rxValid) begin // [RULE4]
      case (rxByte)
        CMD_CLASS: if (canAnswer) begin
          data_d = {classRequested, classGranted}; // [RULE6] [RULE17]
          tx_d = TX_START;
        end
        CMD_STATUS: if (canAnswer) begin
          data_d = statusByte; // [RULE7]
          tx_d = TX_START;
        end
        INPUT_VOLTAGE_QUERY_CMD: if (canAnswer) begin
          data_d = inputVoltage[15:8]; // [RULE8] [RULE19]
          pendByte_d = inputVoltage[7:0];
          pend_d = 1'b1;
          tx_d = TX_START;
        end
        KEEPALIVE_PULSE_ENABLE_CMD: begin
          on_d = 1'b1; // [RULE9]
          tx_d = TX_IDLE; // [RULE20] [RULE15]
          pend_d = 1'b0;
        end
        KEEPALIVE_PULSE_DISABLE_CMD: on_d = 1'b0; // [RULE10] [RULE16]
        default: ; // [RULE21]
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tx_q <= TX_IDLE;
      bit_q <= '0;
      idx_q <= '0;
      data_q <= 8'h00;
      pendByte_q <= 8'h00;
      pend_q <= 1'b0;
      on_q <= 1'b0; // [RULE11]
    end else begin
      tx_q <= tx_d;
      bit_q <= bit_d; // [RULE1]
      idx_q <= idx_d;
      data_q <= data_d;
      pendByte_q <= pendByte_d;
      pend_q <= pend_d;
      on_q <= on_d;
    end
  end

  // ==========================================================
  // Keepalive pulse generator
  logic [31:0] pc_q, pc_d;
  logic kind_q, kind_d, lvl_q, lvl_d;
  logic [31:0] highCyc, periodCyc;

  always_comb begin
    kind_d = kind_q;
    pc_d = pc_q + 32'h0000_0001;
    periodCyc = kind_q ? SHORT_PERIOD : LONG_PERIOD; // [RULE13]
    if (!on_q) begin
      pc_d = 32'h0000_0000;
      kind_d = sourcePulseKind;
    end else if (pc_q == periodCyc - 32'h0000_0001) begin
      pc_d = 32'h0000_0000;
      kind_d = sourcePulseKind; // [RULE12]
    end
    highCyc = kind_d ? SHORT_HIGH : LONG_HIGH; // [RULE13]
    lvl_d = on_d && on_q && pc_d < highCyc;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pc_q <= 32'h0000_0000;
      kind_q <= 1'b0;
      lvl_q <= 1'b0;
    end else begin
      pc_q <= pc_d;
      kind_q <= kind_d;
      lvl_q <= lvl_d;
    end
  end

  // ==========================================================
  // Transmit pin
  logic txd_q, txd_d;

  always_comb begin
    case (tx_d)
      TX_START: txd_d = 1'b0;
      TX_DATA: txd_d = data_d[idx_d]; // [RULE2]
      default: txd_d = TX_IDLE_LEVEL;
    endcase
    if (on_d) txd_d = lvl_d; // [RULE14]
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) txd_q <= TX_IDLE_LEVEL;
    else txd_q <= txd_d;
  end

  assign txd = txd_q;
  assign pulsesOn = on_q;
  assign txBusy = tx_q != TX_IDLE || pend_q;

  // ==========================================================
  // Checks
  property p_bitLen;
    @(posedge ref_clk) disable iff (!resetn)
    bit_q <= LAST && (on_q || tx_q == TX_IDLE || bit_q == '0
      || $stable(txd));
  endproperty
  a_bitLen: assert property (p_bitLen) // [RULE1]
    else $error("bit counter overran bit time");

  property p_frameLevels;
    @(posedge ref_clk) disable iff (!resetn)
    !on_q |-> txd == (tx_q == TX_START ? 1'b0 :
      tx_q == TX_DATA ? data_q[idx_q] : 1'b1);
  endproperty
  a_frameLevels: assert property (p_frameLevels) // [RULE2]
    else $error("transmit level does not match frame");

  property p_classResp;
    @(posedge ref_clk) disable iff (!resetn)
    rxValid && rxByte == CMD_CLASS && canAnswer |=> tx_q == TX_START
      && data_q == $past({classRequested, classGranted});
  endproperty
  a_classResp: assert property (p_classResp) // [RULE6] [RULE17]
    else $error("class answer wrong");

  property p_statusResp;
    @(posedge ref_clk) disable iff (!resetn)
    rxValid && rxByte == CMD_STATUS && canAnswer |=>
      data_q[7:5] == {2'b00, $past(sourcePulseKind)}
      && data_q[2:0] == $past(levelPulseCount) && !data_q[3]
      && data_q[4] == $past(autoclassEn);
  endproperty
  a_statusResp: assert property (p_statusResp) // [RULE7] [RULE18]
    else $error("status answer wrong");

  property p_voltResp;
    @(posedge ref_clk) disable iff (!resetn)
    rxValid && rxByte == INPUT_VOLTAGE_QUERY_CMD && canAnswer |=>
      data_q == $past(inputVoltage[15:8]) && pend_q
      && pendByte_q == $past(inputVoltage[7:0]);
  endproperty
  a_voltResp: assert property (p_voltResp) // [RULE8] [RULE19]
    else $error("voltage answer wrong");

  property p_enable;
    @(posedge ref_clk) disable iff (!resetn)
    rxValid && rxByte == KEEPALIVE_PULSE_ENABLE_CMD |=>
      on_q && tx_q == TX_IDLE && !pend_q;
  endproperty
  a_enable: assert property (p_enable) // [RULE9] [RULE20]
    else $error("enable not taken or answer sent");

  property p_disable;
    @(posedge ref_clk) disable iff (!resetn)
    rxValid && rxByte == KEEPALIVE_PULSE_DISABLE_CMD |=> ##1
      !on_q && txd;
  endproperty
  a_disable: assert property (p_disable) // [RULE10] [RULE16]
    else $error("disable did not restore serial idle");

  property p_noSelfStart;
    @(posedge ref_clk) disable iff (!resetn)
    !on_q && !(rxValid && rxByte == KEEPALIVE_PULSE_ENABLE_CMD)
      |=> !on_q;
  endproperty
  a_noSelfStart: assert property (p_noSelfStart) // [RULE11]
    else $error("pulses started without command");

  property p_pulseLine;
    @(posedge ref_clk) disable iff (!resetn)
    on_q && $past(on_q) |-> txd == lvl_q
      && (!lvl_q || pc_q < (kind_q ? SHORT_HIGH : LONG_HIGH));
  endproperty
  a_pulseLine: assert property (p_pulseLine) // [RULE12] [RULE14]
    else $error("pulse line wrong");

  property p_unknown;
    @(posedge ref_clk) disable iff (!resetn)
    rxValid && (rxByte == 8'h00 || rxByte > 8'h05) && tx_q == TX_IDLE
      && !pend_q |=> tx_q == TX_IDLE && $stable(on_q);
  endproperty
  a_unknown: assert property (p_unknown) // [RULE21]
    else $error("unknown code changed state");

  c_class: cover property (@(posedge ref_clk)
    rxValid && rxByte == CMD_CLASS && canAnswer);
  c_volt: cover property (@(posedge ref_clk)
    tx_q == TX_IDLE && pend_q);
  c_pulse: cover property (@(posedge ref_clk) on_q && lvl_q);
  c_off: cover property (@(posedge ref_clk)
    $fell(on_q));
endmodule : pdu_cmd_port

// file: pdu_pkg.sv
// Constants and types for the command port
package pdu_pkg;
  // ==========================================================
  // Link timing
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned BAUD_BPS = 9600;
  localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD_BPS;
  localparam int unsigned DATA_BITS = 8;
  localparam logic TX_IDLE_LEVEL = 1'b1;
  // ==========================================================
  // Command codes
  localparam logic [7:0] CMD_CLASS = 8'h01;
  localparam logic [7:0] CMD_STATUS = 8'h02;
  localparam logic [7:0] INPUT_VOLTAGE_QUERY_CMD = 8'h03;
  localparam logic [7:0] KEEPALIVE_PULSE_ENABLE_CMD = 8'h04;
  localparam logic [7:0] KEEPALIVE_PULSE_DISABLE_CMD = 8'h05;
  // ==========================================================
  // Response fields
  localparam int unsigned CLASS_REQ_LSB = 4;
  localparam int unsigned STATUS_KIND_BIT = 5;
  localparam int unsigned STATUS_AUTO_BIT = 4;
  // ==========================================================
  // Keepalive pulse timing, ms and cycles
  localparam int unsigned CYCLES_PER_MS = CLK_HZ / 1000;
  localparam int unsigned LONG_HIGH_MS = 100;
  localparam int unsigned LONG_PERIOD_MS = 300;
  localparam int unsigned SHORT_HIGH_MS = 10;
  localparam int unsigned SHORT_PERIOD_MS = 300;
  localparam int unsigned LONG_HIGH_CYC = LONG_HIGH_MS * CYCLES_PER_MS;
  localparam int unsigned LONG_PERIOD_CYC = LONG_PERIOD_MS * CYCLES_PER_MS;
  localparam int unsigned SHORT_HIGH_CYC = SHORT_HIGH_MS * CYCLES_PER_MS;
  localparam int unsigned SHORT_PERIOD_CYC =
    SHORT_PERIOD_MS * CYCLES_PER_MS;
  // ==========================================================
  // States
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00, TX_START = 2'b01, TX_DATA = 2'b10, TX_STOP = 2'b11
  } pdu_tx_e;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10, RX_STOP = 2'b11
  } pdu_rx_e;
endpackage : pdu_pkg

// file: pdu_uart_rx.sv
// Serial byte receiver for the command port
`timescale 1ns/1ns
module pdu_uart_rx
  import pdu_pkg::*;
#(
  parameter int unsigned BIT_CYC = BIT_CYCLES
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic rxd,
  output logic [7:0] rxByte,
  output logic rxValid
);
  localparam int unsigned BW = $clog2(BIT_CYC + 1);
  localparam logic [BW-1:0] LAST = BW'(BIT_CYC - 1);
  localparam logic [BW-1:0] HALF = BW'(BIT_CYC / 2 - 1);

  pdu_rx_e st_q, st_d;
  logic [BW-1:0] cnt_q, cnt_d;
  logic [2:0] idx_q, idx_d;
  logic [7:0] sh_q, sh_d, byte_q, byte_d;
  logic vld_q, vld_d;

  // ==========================================================
  // Frame sampling
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q + BW'(1);
    idx_d = idx_q;
    sh_d = sh_q;
    byte_d = byte_q;
    vld_d = 1'b0;
    case (st_q)
      RX_IDLE: begin
        cnt_d = '0;
        if (!rxd) st_d = RX_START; // [RULE3]
      end
      RX_START: if (cnt_q == HALF) begin
        cnt_d = '0;
        idx_d = '0;
        st_d = rxd ? RX_IDLE : RX_DATA; // [RULE2]
      end
      RX_DATA: if (cnt_q == LAST) begin
        cnt_d = '0;
        sh_d = {rxd, sh_q[7:1]}; // [RULE2]
        if (idx_q == 3'h7) st_d = RX_STOP;
        else idx_d = idx_q + 3'h1;
      end
      RX_STOP: if (cnt_q == LAST) begin
        st_d = RX_IDLE;
        if (rxd) begin
          vld_d = 1'b1;
          byte_d = sh_q;
        end
      end
      default: st_d = RX_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= RX_IDLE;
      cnt_q <= '0;
      idx_q <= '0;
      sh_q <= 8'h00;
      byte_q <= 8'h00;
      vld_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      idx_q <= idx_d;
      sh_q <= sh_d;
      byte_q <= byte_d;
      vld_q <= vld_d;
    end
  end

  assign rxByte = byte_q;
  assign rxValid = vld_q;

  // ==========================================================
  // Checks
  property p_rxPulse;
    @(posedge ref_clk) disable iff (!resetn)
    rxValid |-> ($past(rxd) && $past(st_q == RX_STOP)) ##1 !rxValid;
  endproperty
  a_rxPulse: assert property (p_rxPulse) // [RULE3] [RULE2]
    else $error("receive strobe longer than one cycle");
endmodule : pdu_uart_rx

// file: pdu_ctrl_model.sv
// Controller side model of the serial command link
`timescale 1ns/1ns
module pdu_ctrl_model
  import pdu_pkg::*;
#(
  parameter int unsigned BIT_CYC = 16
) (
  input wire logic ref_clk,
  output logic txLine,
  input wire logic rxLine
);
  // ==========================================================
  // Idle line
  initial txLine = 1'b1;

  // ==========================================================
  // Send one frame, fixed bit time
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      txLine <= frame[i];
      repeat (BIT_CYC) @(posedge ref_clk);
    end
  endtask : send_byte

  // ==========================================================
  // Receive one frame, LSB first, stop checked
  task automatic recv_byte(input int limit, output logic [7:0] b,
                           output bit got);
    int n;
    b = 8'h00;
    got = 1'b0;
    n = 0;
    while (rxLine !== 1'b0 && n < limit) begin
      @(posedge ref_clk);
      n++;
    end
    if (rxLine !== 1'b0) return;
    repeat (BIT_CYC / 2) @(posedge ref_clk);
    if (rxLine !== 1'b0) return;
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge ref_clk);
      b[i] = rxLine;
    end
    repeat (BIT_CYC) @(posedge ref_clk);
    got = (rxLine === 1'b1);
  endtask : recv_byte
endmodule : pdu_ctrl_model

// file: pdu_cmd_port_tb.sv
// Self-checking testbench for the serial command port
`timescale 1ns/1ns
module pdu_cmd_port_tb;
  import pdu_pkg::*;
  localparam int BC = 16;
  localparam int LH = 4;
  localparam int SH = 2;
  localparam int SP = 12;
  logic refClk, resetn, rxd, txd, pulsesOn, txBusy;
  logic [3:0] classRequested, classGranted;
  logic autoclassEn, sourcePulseKind;
  logic [2:0] levelPulseCount;
  logic [15:0] inputVoltage;
  logic [7:0] junk [5] = '{8'h00, 8'h06, 8'h7F, 8'h80, 8'hFF};
  int nFail = 0;
  int compares = 0;

  // ==========================================================
  // Clock, design and controller model
  initial refClk = 1'b0;
  always #4 refClk = ~refClk;
  pdu_cmd_port #(.BIT_CYC(BC), .LONG_HIGH(LH), .LONG_PERIOD(SP),
    .SHORT_HIGH(SH), .SHORT_PERIOD(SP)) DUT (.ref_clk(refClk),
    .resetn(resetn), .rxd(rxd), .txd(txd),
    .classRequested(classRequested), .classGranted(classGranted),
    .autoclassEn(autoclassEn), .levelPulseCount(levelPulseCount),
    .sourcePulseKind(sourcePulseKind), .inputVoltage(inputVoltage),
    .pulsesOn(pulsesOn), .txBusy(txBusy));
  pdu_ctrl_model #(.BIT_CYC(BC)) CTRL (.ref_clk(refClk), .txLine(rxd),
    .rxLine(txd));

  // ==========================================================
  // Compare and closing tasks
  task automatic wrap_up();
    if (nFail == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      nFail++;
      $display("mismatch at %0t: byte %h exp %h", $time, got, exp);
    end
  endtask : chk_byte
  task automatic chk_flag(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      nFail++;
      $display("mismatch at %0t: flag %b exp %b", $time, got, exp);
    end
  endtask : chk_flag
  task automatic chk_count(input int got, input int exp);
    compares++;
    if (got != exp) begin
      nFail++;
      $display("mismatch at %0t: count %0d exp %0d", $time, got, exp);
    end
  endtask : chk_count

  // ==========================================================
  // Command tasks
  task automatic read_cmd(input logic [7:0] code, input int nb,
                          input logic [15:0] exp);
    logic [7:0] b0, b1;
    bit g0, g1;
    int n;
    fork
      CTRL.send_byte(code);
      CTRL.recv_byte(30 * BC, b0, g0);
    join
    chk_flag(g0, 1'b1);
    chk_byte(b0, (nb == 2) ? exp[15:8] : exp[7:0]);
    if (nb == 2) begin
      CTRL.recv_byte(4 * BC, b1, g1);
      chk_flag(g1, 1'b1);
      chk_byte(b1, exp[7:0]);
    end
    n = 0;
    while (txBusy !== 1'b0 && n < 4 * BC) begin
      @(posedge refClk);
      n++;
    end
    chk_flag(txBusy, 1'b0);
  endtask : read_cmd
  task automatic quiet_cmd(input logic [7:0] code, input bit lineToo);
    int bad;
    bad = 0;
    CTRL.send_byte(code);
    repeat (20 * BC) begin
      @(posedge refClk);
      if (txBusy !== 1'b0 || (lineToo && txd !== 1'b1)) bad++;
    end
    chk_count(bad, 0);
  endtask : quiet_cmd
  task automatic pulse_check(input int expHigh);
    int hi, per, n;
    hi = 0;
    n = 0;
    while (txd !== 1'b0 && n < 4 * SP) begin
      @(posedge refClk);
      n++;
    end
    while (txd !== 1'b1 && n < 8 * SP) begin
      @(posedge refClk);
      n++;
    end
    while (txd === 1'b1 && hi < 4 * SP) begin
      @(posedge refClk);
      hi++;
    end
    per = hi;
    while (txd === 1'b0 && per < 4 * SP) begin
      @(posedge refClk);
      per++;
    end
    chk_count(hi, expHigh);
    chk_count(per, SP);
  endtask : pulse_check

  // ==========================================================
  // Watchdog
  initial begin
    repeat (40000) @(posedge refClk);
    nFail++;
    $display("mismatch at %0t: watchdog expired", $time);
    wrap_up();
  end

  // ==========================================================
  // Main sequence
  initial begin
    resetn <= 1'b0;
    classRequested <= 4'hA;
    classGranted <= 4'h5;
    autoclassEn <= 1'b0;
    levelPulseCount <= 3'h5;
    sourcePulseKind <= 1'b1;
    inputVoltage <= 16'hC3A5;
    repeat (20) @(posedge refClk);
    chk_flag(txd, 1'b1);
    chk_flag(pulsesOn, 1'b0);
    chk_flag(txBusy, 1'b0);
    resetn <= 1'b1;
    @(posedge refClk);
    foreach (junk[i]) begin
      quiet_cmd(junk[i], 1'b1);
      chk_flag(pulsesOn, 1'b0);
    end
    read_cmd(CMD_CLASS, 1, 16'h00A5);
    classRequested <= 4'h3;
    classGranted <= 4'hC;
    read_cmd(CMD_CLASS, 1, 16'h003C);
    read_cmd(CMD_STATUS, 1, 16'h0025);
    sourcePulseKind <= 1'b0;
    autoclassEn <= 1'b1;
    levelPulseCount <= 3'h2;
    read_cmd(CMD_STATUS, 1, 16'h0012);
    read_cmd(INPUT_VOLTAGE_QUERY_CMD, 2, 16'hC3A5);
    // Controller ignores all received data while pulsing
    quiet_cmd(KEEPALIVE_PULSE_ENABLE_CMD, 1'b0);
    chk_flag(pulsesOn, 1'b1);
    pulse_check(LH);
    sourcePulseKind <= 1'b1;
    pulse_check(SH);
    pulse_check(SH);
    quiet_cmd(CMD_CLASS, 1'b0);
    quiet_cmd(8'h06, 1'b0);
    chk_flag(pulsesOn, 1'b1);
    CTRL.send_byte(KEEPALIVE_PULSE_DISABLE_CMD);
    @(posedge refClk);
    chk_flag(pulsesOn, 1'b0);
    chk_flag(txd, 1'b1);
    read_cmd(CMD_CLASS, 1, 16'h003C);
    wrap_up();
  end
endmodule : pdu_cmd_port_tb
